// ---- verilog/cbtc_pkg.sv ----
/*
 * Package for the command bus termination control block: register map,
 * field positions, reset values and resistance code decode constants.
 * Assumes an AXI4-Lite register bus with 32-bit data.
 */
package cbtc_pkg;
    // ************************************************************
    // Register map (byte addresses)
    // ************************************************************
    localparam logic [7:0] ADDR_TERM_MODE   = 8'h00;
    localparam logic [7:0] ADDR_TERM_ENABLE = 8'h04;
    localparam logic [7:0] ADDR_STATUS      = 8'h08;
    localparam logic [7:0] ADDR_POWER       = 8'h0C;

    // ************************************************************
    // Fields
    // ************************************************************
    localparam int RES_LSB      = 4;
    localparam int RES_MSB      = 6;
    localparam int CK_EN_BIT    = 3;
    localparam int CS_EN_BIT    = 4;
    localparam int CA_DIS_BIT   = 5;
    localparam int ST_CA_BIT    = 0;
    localparam int ST_CK_BIT    = 1;
    localparam int ST_CS_BIT    = 2;
    localparam int ST_STRAP_BIT = 3;
    localparam int ST_RES_LSB   = 4;
    localparam int ST_VALID_BIT = 8;
    localparam int ST_PD_BIT    = 9;
    localparam int PD_BIT       = 0;
    localparam int SR_BIT       = 1;

    // ************************************************************
    // Codes and reset values
    // ************************************************************
    localparam logic [2:0]  RES_DISABLED  = 3'h0;
    localparam logic [2:0]  RES_RESERVED  = 3'h7;
    localparam logic [31:0] TERM_MODE_RST = 32'h0000_0000;
    localparam logic [31:0] TERM_EN_RST   = 32'h0000_0000;
    localparam logic [1:0]  RESP_OKAY     = 2'h0;
    localparam logic [1:0]  RESP_SLVERR   = 2'h2;

    typedef struct packed {
        logic       ca_on;
        logic       ck_on;
        logic       cs_on;
        logic [2:0] res_code;
        logic [8:0] ohms;
    } cbtc_term_t;
endpackage

// ---- verilog/cbtc_decode.sv ----
/*
 * Combinational termination state decode from the resistance code,
 * the multirank strap and the enable/disable bits.
 * Assumes all inputs are registered in the caller's clock domain.
 */
`timescale 1ns/10ps
module cbtc_decode (
    // Configuration
    input  wire logic [2:0]        res_code,
    input  wire logic              multirank_term_strap,
    input  wire logic              ca_term_disable_bit,
    input  wire logic              clk_term_enable_bit,
    input  wire logic              chipsel_term_enable_bit,
    // Result
    output cbtc_pkg::cbtc_term_t   term
);
    logic valid;

    always_comb begin
        valid = (res_code != cbtc_pkg::RES_DISABLED) &&    // [RL10]
                (res_code != cbtc_pkg::RES_RESERVED);
        term = '0;
        term.res_code = res_code;                          // [RL1]
        unique case (res_code)                             // [RL7]
            3'h1: term.ohms = 9'h0F0;
            3'h2: term.ohms = 9'h078;
            3'h3: term.ohms = 9'h050;
            3'h4: term.ohms = 9'h03C;
            3'h5: term.ohms = 9'h030;
            3'h6: term.ohms = 9'h028;
            default: term.ohms = 9'h000;
        endcase
        if (!valid) begin                                  // [RL6]
            term.ca_on = 1'b0;
            term.ck_on = 1'b0;
            term.cs_on = 1'b0;
        end else if (!multirank_term_strap) begin          // [RL4]
            term.ca_on = 1'b0;
            term.ck_on = clk_term_enable_bit;
            term.cs_on = chipsel_term_enable_bit;
        end else begin                                     // [RL5]
            term.ca_on = !ca_term_disable_bit;
            term.ck_on = 1'b1;
            term.cs_on = 1'b1;
        end
    end
endmodule

// ---- verilog/cbtc_top.sv ----
/*
 * Command bus termination control with an AXI4-Lite register slave.
 * Assumes the strap and power-state pins are asynchronous levels.
 */
// Function
// RL1: resistance code from mode register bits 6:4
// RL2: termination disabled after reset
// RL3: termination held during power-down and self refresh
// RL4: strap low: CA off, CK/CS follow enables
// RL5: strap high: all on, CA disable bit
// RL6: disabled code turns all termination off
// RL7: codes 1..6 decode to 240..40 ohms
// RL8: power-down leaves strap-derived state untouched
// RL9: controller trains terminating rank first
// RL10: code 0 disabled, code 7 reserved
`timescale 1ns/10ps
module cbtc_top (
    // Clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // AXI4-Lite write
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // AXI4-Lite read
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // Pins
    input  wire logic        multirank_term_strap,
    input  wire logic        power_down,
    input  wire logic        self_refresh,
    // Termination outputs
    output logic             ca_term_on,
    output logic             ck_term_on,
    output logic             cs_term_on,
    output logic [2:0]       term_res_code
);
    // ************************************************************
    // Pin synchronisers
    // ************************************************************
    logic [2:0] pin_meta_reg;
    logic [2:0] pin_sync_reg;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin_meta_reg <= 3'h0;
            pin_sync_reg <= 3'h0;
        end else begin
            pin_meta_reg <= {self_refresh, power_down, multirank_term_strap};
            pin_sync_reg <= pin_meta_reg;
        end
    end
    logic strap_s;
    logic pd_s;
    logic sr_s;
    assign strap_s = pin_sync_reg[0];
    assign pd_s    = pin_sync_reg[1];
    assign sr_s    = pin_sync_reg[2];

    // ************************************************************
    // Write channel
    // ************************************************************
    logic        aw_held_reg;
    logic        w_held_reg;
    logic [7:0]  awaddr_reg;
    logic [31:0] wdata_reg;
    logic [3:0]  wstrb_reg;
    logic        bvalid_reg;
    logic [1:0]  bresp_reg;
    logic [31:0] term_mode_reg;
    logic [31:0] termination_enable_reg;
    logic        do_write;

    assign s_axi_awready = !aw_held_reg && !bvalid_reg;
    assign s_axi_wready  = !w_held_reg && !bvalid_reg;
    assign do_write      = aw_held_reg && w_held_reg && !bvalid_reg;
    assign s_axi_bvalid  = bvalid_reg;
    assign s_axi_bresp   = bresp_reg;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_reg <= 1'b0;
            w_held_reg  <= 1'b0;
            awaddr_reg  <= 8'h00;
            wdata_reg   <= 32'h0000_0000;
            wstrb_reg   <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_reg <= 1'b1;
                awaddr_reg  <= s_axi_awaddr;
            end else if (do_write) begin
                aw_held_reg <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_reg <= 1'b1;
                wdata_reg  <= s_axi_wdata;
                wstrb_reg  <= s_axi_wstrb;
            end else if (do_write) begin
                w_held_reg <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_reg <= 1'b0;
            bresp_reg  <= cbtc_pkg::RESP_OKAY;
        end else if (do_write) begin
            bvalid_reg <= 1'b1;
            bresp_reg  <= (awaddr_reg[7:2] == cbtc_pkg::ADDR_TERM_MODE[7:2] ||
                           awaddr_reg[7:2] == cbtc_pkg::ADDR_TERM_ENABLE[7:2])
                          ? cbtc_pkg::RESP_OKAY : cbtc_pkg::RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_reg <= 1'b0;
        end
    end

    // ************************************************************
    // Mode registers; only byte 0 holds defined bits
    // ************************************************************
    // Power state pins never touch these, so termination holds through them
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            term_mode_reg          <= cbtc_pkg::TERM_MODE_RST;   // [RL2]
            termination_enable_reg <= cbtc_pkg::TERM_EN_RST;
        end else if (do_write && wstrb_reg[0]) begin
            if (awaddr_reg[7:2] == cbtc_pkg::ADDR_TERM_MODE[7:2])
                term_mode_reg <= {24'h000000, 1'b0, wdata_reg[6:0]};
            if (awaddr_reg[7:2] == cbtc_pkg::ADDR_TERM_ENABLE[7:2])
                termination_enable_reg <= {24'h000000, 2'b00, wdata_reg[5:3], 3'b000};
        end
    end

    // ************************************************************
    // Termination decode
    // ************************************************************
    cbtc_pkg::cbtc_term_t term;
    cbtc_decode u_decode (
        .res_code                (term_mode_reg[cbtc_pkg::RES_MSB:cbtc_pkg::RES_LSB]), // [RL1]
        .multirank_term_strap    (strap_s),                                          // [RL8]
        .ca_term_disable_bit     (termination_enable_reg[cbtc_pkg::CA_DIS_BIT]),
        .clk_term_enable_bit     (termination_enable_reg[cbtc_pkg::CK_EN_BIT]),
        .chipsel_term_enable_bit (termination_enable_reg[cbtc_pkg::CS_EN_BIT]),
        .term                    (term)
    );

    // Outputs ignore power-down and self refresh on purpose
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ca_term_on    <= 1'b0;                         // [RL2]
            ck_term_on    <= 1'b0;
            cs_term_on    <= 1'b0;
            term_res_code <= cbtc_pkg::RES_DISABLED;
        end else begin
            ca_term_on    <= term.ca_on;                   // [RL3]
            ck_term_on    <= term.ck_on;
            cs_term_on    <= term.cs_on;
            term_res_code <= term.res_code;
        end
    end

    // ************************************************************
    // Read channel
    // ************************************************************
    logic        rvalid_reg;
    logic [31:0] rdata_reg;
    logic [1:0]  rresp_reg;
    assign s_axi_arready = !rvalid_reg;
    assign s_axi_rvalid  = rvalid_reg;
    assign s_axi_rdata   = rdata_reg;
    assign s_axi_rresp   = rresp_reg;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_reg <= 1'b0;
            rdata_reg  <= 32'h0000_0000;
            rresp_reg  <= cbtc_pkg::RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            rvalid_reg <= 1'b1;
            rresp_reg  <= cbtc_pkg::RESP_OKAY;
            unique case (s_axi_araddr[7:2])
                cbtc_pkg::ADDR_TERM_MODE[7:2]:   rdata_reg <= term_mode_reg;
                cbtc_pkg::ADDR_TERM_ENABLE[7:2]: rdata_reg <= termination_enable_reg;
                cbtc_pkg::ADDR_STATUS[7:2]:      rdata_reg <= {22'h0,
                    pd_s | sr_s, term.ohms != 9'h000, 1'b0, term_res_code,
                    strap_s, cs_term_on, ck_term_on, ca_term_on};
                cbtc_pkg::ADDR_POWER[7:2]:       rdata_reg <= {30'h0, sr_s, pd_s};
                default: begin
                    rdata_reg <= 32'h0000_0000;
                    rresp_reg <= cbtc_pkg::RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rready) begin
            rvalid_reg <= 1'b0;
        end
    end

    // ************************************************************
    // Assertions
    // ************************************************************
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    strap_low_ca_a: assert property (!pin_sync_reg[0] |=> !ca_term_on) // [RL4]
        else $error("CA terminated with strap low");
    code_off_a: assert property ( // [RL6]
        term_mode_reg[6:4] == 3'h0 |=> !(ca_term_on | ck_term_on | cs_term_on))
        else $error("Termination on with disabled code");
    reserved_off_a: assert property ( // [RL10]
        term_mode_reg[6:4] == 3'h7 |=> !(ca_term_on | ck_term_on | cs_term_on))
        else $error("Termination on with reserved code");
    strap_high_ck_a: assert property ( // [RL5]
        strap_s && term.res_code inside {[3'h1:3'h6]} |=> ck_term_on && cs_term_on)
        else $error("CK or CS off with strap high");
    ca_disable_a: assert property (strap_s && termination_enable_reg[5] |=> !ca_term_on) // [RL5]
        else $error("CA on while disabled");
    ck_follow_a: assert property ( // [RL4]
        !strap_s && term.res_code == 3'h2 |=> ck_term_on == $past(termination_enable_reg[3]))
        else $error("CK does not follow enable");
    pd_hold_a: assert property ( // [RL3]
        $rose(pd_s) && $stable(term_mode_reg) && $stable(termination_enable_reg) &&
        $stable(strap_s) |=> $stable(ca_term_on))
        else $error("Power-down altered termination");
    code_out_a: assert property ( // [RL1]
        $changed(term_mode_reg[6:4]) |=> term_res_code == $past(term_mode_reg[6:4]))
        else $error("Resistance code not propagated");
    ohms_a: assert property (term_mode_reg[6:4] == 3'h1 |-> term.ohms == 9'h0F0) // [RL7]
        else $error("Code 1 not 240 ohms");
    ohms_low_a: assert property (term_mode_reg[6:4] == 3'h6 |-> term.ohms == 9'h028) // [RL7]
        else $error("Code 6 not 40 ohms");
    reset_off_a: assert property ($rose(aresetn) |-> !ca_term_on && !ck_term_on) // [RL2]
        else $error("Termination on after reset");

    cov_all_on_c: cover property (ca_term_on && ck_term_on && cs_term_on);
    cov_ck_only_c: cover property (!ca_term_on && ck_term_on && !strap_s);
    cov_pd_on_c: cover property (pd_s && ca_term_on);
    cov_bad_rd_c: cover property (s_axi_rvalid && s_axi_rresp == cbtc_pkg::RESP_SLVERR);
endmodule

// ---- tb/cbtc_ctrl_model.sv ----
/*
 * Controller model: programs the termination block over AXI4-Lite.
 * Assumes one clock shared with the block.
 */
`timescale 1ns/10ps
module cbtc_ctrl_model (
    // Clock
    input  wire logic        aclk,
    // Write channels
    output logic [7:0]       s_axi_awaddr,
    output logic             s_axi_awvalid,
    input  wire logic        s_axi_awready,
    output logic [31:0]      s_axi_wdata,
    output logic [3:0]       s_axi_wstrb,
    output logic             s_axi_wvalid,
    input  wire logic        s_axi_wready,
    input  wire logic [1:0]  s_axi_bresp,
    input  wire logic        s_axi_bvalid,
    output logic             s_axi_bready,
    // Read channels
    output logic [7:0]       s_axi_araddr,
    output logic             s_axi_arvalid,
    input  wire logic        s_axi_arready,
    input  wire logic [31:0] s_axi_rdata,
    input  wire logic [1:0]  s_axi_rresp,
    input  wire logic        s_axi_rvalid,
    output logic             s_axi_rready
);
    initial begin
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
        {s_axi_arvalid, s_axi_rready} = 2'h0;
        s_axi_wstrb = 4'hF;
    end

    // ******************************
    // Bus tasks
    // ******************************
    // Released payload is inverted so a slave sampling it late is caught
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        do begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) begin
                s_axi_awvalid <= 1'h0;
                s_axi_awaddr <= ~a;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                s_axi_wvalid <= 1'h0;
                s_axi_wdata <= ~d;
            end
        end while (!(s_axi_bvalid && s_axi_bready));
        s_axi_bready <= 1'h0;
        r = s_axi_bresp;
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        do begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arvalid <= 1'h0;
                s_axi_araddr <= ~a;
            end
        end while (!(s_axi_rvalid && s_axi_rready));
        s_axi_rready <= 1'h0;
        d = s_axi_rdata;
        r = s_axi_rresp;
    endtask
endmodule

// ---- tb/cbtc_top_tb.sv ----
/*
 * Self-checking bench: sweeps code, strap and enable bits, power states,
 * bus errors and reset. Assumes the controller model drives the bus.
 */
`timescale 1ns/10ps
module cbtc_top_tb;
    logic        aclk, aresetn;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rdat;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic        s_axi_rvalid, s_axi_rready;
    logic        multirank_term_strap, power_down, self_refresh;
    logic        ca_term_on, ck_term_on, cs_term_on;
    logic [2:0]  term_res_code;
    wire  [5:0]  outs = {ca_term_on, ck_term_on, cs_term_on, term_res_code};
    int          fails, compares;

    cbtc_top        uut (.*);
    cbtc_ctrl_model ctrl (.*);

    initial aclk = 1'h0;
    always #12.5 aclk = ~aclk;

    // ******************************
    // Helpers
    // ******************************
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic end_sim();
        $display("compares=%0d fails=%0d", compares, fails);
        if (fails == 0 && compares > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // Expected {ca, ck, cs, code}; e is {ca disable, cs enable, ck enable}
    function automatic logic [5:0] want(input logic [2:0] c, input logic s,
                                        input logic [2:0] e);
        if (c == 3'h0 || c == 3'h7)
            return {3'h0, c};
        if (!s)
            return {1'h0, e[0], e[1], c};
        return {~e[2], 2'h3, c};
    endfunction

    task automatic apply(input logic [2:0] c, input logic s, input logic [2:0] e);
        logic [5:0] w;
        w = want(c, s, e);
        @(posedge aclk);
        multirank_term_strap <= s;
        ctrl.wr(cbtc_pkg::ADDR_TERM_MODE, {25'h0, c, 4'h5}, resp);
        ctrl.wr(cbtc_pkg::ADDR_TERM_ENABLE, {26'h0, e, 3'h0}, resp);
        repeat (4) @(posedge aclk);
        check({26'h0, outs}, {26'h0, w});
        ctrl.rd(cbtc_pkg::ADDR_STATUS, rdat, resp);
        check(rdat, {23'h0, c != 3'h0 && c != 3'h7, 1'h0, c, s, w[3], w[4], w[5]});
    endtask

    task automatic check_reset();
        repeat (2) @(posedge aclk);
        check({26'h0, outs}, 32'h0);
        ctrl.rd(cbtc_pkg::ADDR_TERM_MODE, rdat, resp);
        check(rdat, cbtc_pkg::TERM_MODE_RST);
        ctrl.rd(cbtc_pkg::ADDR_TERM_ENABLE, rdat, resp);
        check(rdat, cbtc_pkg::TERM_EN_RST);
    endtask

    // ******************************
    // Tests
    // ******************************
    initial begin
        repeat (10000) @(posedge aclk);
        fails++;
        end_sim();
    end

    initial begin
        aresetn = 1'h0;
        multirank_term_strap = 1'h0;
        power_down = 1'h0;
        self_refresh = 1'h0;
        fails = 0;
        compares = 0;
        repeat (16) @(posedge aclk);
        aresetn <= 1'h1;
        check_reset();
        $display("test reset done");
        // Terminating rank is set up first
        for (int s = 1; s >= 0; s--) begin
            for (int c = 0; c < 8; c++) begin
                for (int e = 0; e < 8; e++) begin
                    apply(3'(c), 1'(s), 3'(e));
                end
            end
        end
        $display("test decode sweep done");
        apply(3'h3, 1'h1, 3'h0);
        power_down <= 1'h1;
        repeat (4) @(posedge aclk);
        check({26'h0, outs}, 32'h3B);
        ctrl.rd(cbtc_pkg::ADDR_POWER, rdat, resp);
        check(rdat, 32'h1);
        self_refresh <= 1'h1;
        repeat (4) @(posedge aclk);
        check({26'h0, outs}, 32'h3B);
        ctrl.rd(cbtc_pkg::ADDR_STATUS, rdat, resp);
        check(rdat, 32'h33F);
        ctrl.rd(cbtc_pkg::ADDR_POWER, rdat, resp);
        check(rdat, 32'h3);
        power_down <= 1'h0;
        self_refresh <= 1'h0;
        $display("test power states done");
        ctrl.rd(8'h10, rdat, resp);
        check({30'h0, resp}, {30'h0, cbtc_pkg::RESP_SLVERR});
        check(rdat, 32'h0);
        ctrl.wr(8'h10, 32'hFF, resp);
        check({30'h0, resp}, {30'h0, cbtc_pkg::RESP_SLVERR});
        $display("test bus errors done");
        apply(3'h1, 1'h1, 3'h0);
        aresetn <= 1'h0;
        repeat (16) @(posedge aclk);
        aresetn <= 1'h1;
        check_reset();
        $display("test mid-run reset done");
        end_sim();
    end
endmodule
